// File: ast_pkg.sv
// shared constants and types of the axis self test block
package ast_pkg;
    // clock period of the bit clock domain
    localparam int CLK_NS = 50;
    // half of the alternating force period (100 Hz square wave)
    localparam int AC_HALF_NS = 5000000;
    // cycles per half period
    localparam int AC_HALF_CYC = AC_HALF_NS / CLK_NS;
    // register offsets on the two-wire port
    localparam logic [7:0] X_CTRL_ADDR = 8'h84;
    localparam logic [7:0] Y_CTRL_ADDR = 8'h86;
    localparam logic [7:0] Z_CTRL_ADDR = 8'h88;
    localparam logic [7:0] FILT_ADDR = 8'h85;
    localparam logic [7:0] STAT_ADDR = 8'h87;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] FILT_RST = 8'h00;
    // field positions in a force control register
    localparam int NEG_BIT = 0;
    localparam int POS_BIT = 1;
    localparam int AC_BIT = 2;
    // field positions in the filter register
    localparam int CIC_SEL_LSB = 0;
    localparam int IIR_SEL_LSB = 2;
    // excitation in counts at 500 counts per g: 3.6 g and 6.6 g
    localparam logic signed [15:0] EXC_HORZ = 16'h0708;
    localparam logic signed [15:0] EXC_VERT = 16'h0CE4;
    // slave address on the two-wire port, arbitrary value
    localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A;

    // force applied to one axis
    typedef enum logic [1:0] {FORCE_NONE, FORCE_NEG, FORCE_POS, FORCE_AC} ast_force_t;
    // two-wire slave states
    typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
                              ST_WDATA, ST_WACK, ST_RDATA, ST_RACK} ast_i2c_st_t;

    // exactly one request bit selects a force, anything else selects none
    function automatic ast_force_t ast_decode(input logic [7:0] c);
        ast_force_t f;
        f = FORCE_NONE;
        unique case ({c[AC_BIT], c[POS_BIT], c[NEG_BIT]})
            3'h1: f = FORCE_NEG;
            3'h2: f = FORCE_POS;
            3'h4: f = FORCE_AC;
            default: f = FORCE_NONE;
        endcase
        return f;
    endfunction
endpackage

// File: ast_self_test.sv
`timescale 1ns/1ps
// Notes on behaviour
// - each axis has its own force control
// - exactly one request bit applies force, else none
// - positive force: +3.6 g horizontal, +6.6 g vertical
// - negative force: -3.6 g horizontal, -6.6 g vertical
// - alternating force: 100 Hz square between both levels
// - output is excitation plus external acceleration
// - controls at 0x84, 0x86, 0x88; software clears first
// - three axes processed in separate digital paths
// - comb-integrator stage then single-pole recursive stage
// - four cutoffs per stage, sixteen combinations
// - all timing from the external bit clock
// - registers reached over two-wire port as slave
module ast_self_test import ast_pkg::*; #(
    parameter int unsigned HALF_CYC = AC_HALF_CYC, // cycles per half of the square wave
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT // slave address, arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic signed [15:0] sample_x,
    input wire logic signed [15:0] sample_y,
    input wire logic signed [15:0] sample_z,
    input wire logic sample_valid_x,
    input wire logic sample_valid_y,
    input wire logic sample_valid_z,
    output logic signed [15:0] accel_x,
    output logic signed [15:0] accel_y,
    output logic signed [15:0] accel_z,
    output logic accel_valid_x,
    output logic accel_valid_y,
    output logic accel_valid_z
);
    localparam int CW = $clog2(HALF_CYC + 1);

    // refuse a square wave shorter than two cycles per half
    if (HALF_CYC < 2) begin : g_chk
        $error("HALF_CYC must be at least 2");
    end

    // two-wire slave state
    ast_i2c_st_t state_r, state_nxt;
    logic scl_q_r, sda_q_r; // previous line levels for edge detection
    logic [3:0] bit_cnt_r, bit_cnt_nxt; // bits seen in current byte
    logic [7:0] shift_r, shift_nxt; // byte being shifted
    logic [7:0] ptr_r, ptr_nxt; // register pointer, increments per byte
    logic rw_r, rw_nxt; // read when set
    logic nack_r, nack_nxt; // master refused the last read byte
    logic oe_r, oe_nxt; // pulling data line low
    logic wr_en; // write strobe for the addressed register
    logic [7:0] rd_byte; // value of the addressed register
    logic scl_rise, scl_fall, start_c, stop_c;

    // register file
    logic [7:0] ctrl_r [3]; // force controls per axis
    logic [7:0] ctrl_nxt [3];
    logic [7:0] filt_r, filt_nxt; // cutoff selections of both stages
    logic [7:0] stat_byte; // live force state

    // self test per axis
    ast_force_t force_c [3];
    logic [CW-1:0] ac_cnt_r [3], ac_cnt_nxt [3]; // half period counter
    logic phase_r [3], phase_nxt [3]; // low half of square wave when set
    logic signed [15:0] exc [3]; // excitation in counts

    // data path per axis
    logic signed [15:0] samp [3];
    logic vld [3];
    logic signed [15:0] stim [3]; // sample plus excitation
    logic signed [31:0] int1_r [3], int1_nxt [3], int2_r [3], int2_nxt [3];
    logic signed [31:0] dly1_r [3], dly1_nxt [3], dly2_r [3], dly2_nxt [3];
    logic [2:0] dec_cnt_r [3], dec_cnt_nxt [3]; // decimation phase
    logic signed [15:0] cic_r [3], cic_nxt [3]; // comb-integrator output
    logic cic_vld_r [3], cic_vld_nxt [3];
    logic signed [15:0] iir_r [3], iir_nxt [3]; // recursive stage output
    logic out_vld_r [3], out_vld_nxt [3];

    assign samp[0] = sample_x;
    assign samp[1] = sample_y;
    assign samp[2] = sample_z;
    assign vld[0] = sample_valid_x;
    assign vld[1] = sample_valid_y;
    assign vld[2] = sample_valid_z;

    // open-drain data line: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = oe_r;
    assign accel_x = iir_r[0];
    assign accel_y = iir_r[1];
    assign accel_z = iir_r[2];
    assign accel_valid_x = out_vld_r[0];
    assign accel_valid_y = out_vld_r[1];
    assign accel_valid_z = out_vld_r[2];

    // line events, sampled on the bit clock
    assign scl_rise = scl & ~scl_q_r;
    assign scl_fall = ~scl & scl_q_r;
    assign start_c = scl & scl_q_r & sda_q_r & ~sda_in;
    assign stop_c = scl & scl_q_r & ~sda_q_r & sda_in;

    // read multiplexer, unmapped offsets read zero
    always_comb begin
        unique case (ptr_r)
            X_CTRL_ADDR: rd_byte = ctrl_r[0];
            Y_CTRL_ADDR: rd_byte = ctrl_r[1];
            Z_CTRL_ADDR: rd_byte = ctrl_r[2];
            FILT_ADDR: rd_byte = filt_r;
            STAT_ADDR: rd_byte = stat_byte;
            default: rd_byte = 8'h00;
        endcase
    end

    // two-wire slave next state
    // slave on two-wire port
    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        nack_nxt = nack_r;
        oe_nxt = oe_r;
        wr_en = 1'b0;
        if (start_c) begin
            // start or repeated start
            state_nxt = ST_ADDR;
            bit_cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (stop_c) begin
            state_nxt = ST_IDLE;
            oe_nxt = 1'b0;
        end else if (scl_rise) begin
            unique case (state_r)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    shift_nxt = {shift_r[6:0], sda_in};
                    bit_cnt_nxt = bit_cnt_r + 4'h1;
                end
                ST_RDATA: bit_cnt_nxt = bit_cnt_r + 4'h1;
                ST_RACK: nack_nxt = sda_in;
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (state_r)
                ST_ADDR: if (bit_cnt_r == 4'h8) begin
                    // acknowledge own address only
                    if (shift_r[7:1] == DEV_ADDR) begin
                        state_nxt = ST_ADDR_ACK;
                        rw_nxt = shift_r[0];
                        oe_nxt = 1'b1;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_REG: if (bit_cnt_r == 4'h8) begin
                    ptr_nxt = shift_r;
                    state_nxt = ST_REG_ACK;
                    oe_nxt = 1'b1;
                end
                ST_WDATA: if (bit_cnt_r == 4'h8) begin
                    wr_en = 1'b1;
                    ptr_nxt = ptr_r + 8'h01;
                    state_nxt = ST_WACK;
                    oe_nxt = 1'b1;
                end
                ST_ADDR_ACK: begin
                    bit_cnt_nxt = 4'h0;
                    if (rw_r) begin
                        // load first read byte and drive its top bit
                        state_nxt = ST_RDATA;
                        shift_nxt = rd_byte;
                        ptr_nxt = ptr_r + 8'h01;
                        oe_nxt = ~rd_byte[7];
                    end else begin
                        state_nxt = ST_REG;
                        oe_nxt = 1'b0;
                    end
                end
                ST_REG_ACK, ST_WACK: begin
                    state_nxt = ST_WDATA;
                    bit_cnt_nxt = 4'h0;
                    oe_nxt = 1'b0;
                end
                ST_RDATA: begin
                    if (bit_cnt_r == 4'h8) begin
                        // release for the master acknowledge
                        state_nxt = ST_RACK;
                        oe_nxt = 1'b0;
                    end else begin
                        shift_nxt = {shift_r[6:0], 1'b0};
                        oe_nxt = ~shift_r[6];
                    end
                end
                ST_RACK: begin
                    bit_cnt_nxt = 4'h0;
                    if (nack_r) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt = ST_RDATA;
                        shift_nxt = rd_byte;
                        ptr_nxt = ptr_r + 8'h01;
                        oe_nxt = ~rd_byte[7];
                    end
                end
                default: ;
            endcase
        end
    end

    // register writes
    // one register per write
    always_comb begin
        ctrl_nxt = ctrl_r;
        filt_nxt = filt_r;
        if (wr_en) begin
            unique case (ptr_r)
                X_CTRL_ADDR: ctrl_nxt[0] = shift_r;
                Y_CTRL_ADDR: ctrl_nxt[1] = shift_r;
                Z_CTRL_ADDR: ctrl_nxt[2] = shift_r;
                FILT_ADDR: filt_nxt = shift_r;
                default: ;
            endcase
        end
    end

    // status: active force per axis and square wave phases
    assign stat_byte = {2'h0, force_c[2] != FORCE_NONE, force_c[1] != FORCE_NONE,
                        force_c[0] != FORCE_NONE, phase_r[2], phase_r[1], phase_r[0]};

    // self test force, one independent control per axis
    // per-axis decode and square wave
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            logic signed [15:0] lvl;
            lvl = (i == 2) ? EXC_VERT : EXC_HORZ;
            force_c[i] = ast_decode(ctrl_r[i]);
            ac_cnt_nxt[i] = '0;
            phase_nxt[i] = 1'b0;
            if (force_c[i] == FORCE_AC) begin
                if (ac_cnt_r[i] == CW'(HALF_CYC - 1)) begin
                    phase_nxt[i] = ~phase_r[i];
                end else begin
                    ac_cnt_nxt[i] = ac_cnt_r[i] + CW'(1);
                    phase_nxt[i] = phase_r[i];
                end
            end
            unique case (force_c[i])
                FORCE_POS: exc[i] = lvl;
                FORCE_NEG: exc[i] = -lvl;
                FORCE_AC: exc[i] = phase_r[i] ? -lvl : lvl;
                FORCE_NONE: exc[i] = 16'h0000;
            endcase
            stim[i] = samp[i] + exc[i];
        end
    end

    // filter chain per axis, each with its own valid
    // separate paths per axis
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            logic [1:0] ksel;
            logic [1:0] isel;
            logic signed [31:0] c1;
            logic signed [31:0] c2;
            logic signed [31:0] y32;
            ksel = filt_r[CIC_SEL_LSB +: 2];
            isel = filt_r[IIR_SEL_LSB +: 2];
            c1 = 32'h0;
            c2 = 32'h0;
            y32 = 32'(iir_r[i]);
            int1_nxt[i] = int1_r[i];
            int2_nxt[i] = int2_r[i];
            dly1_nxt[i] = dly1_r[i];
            dly2_nxt[i] = dly2_r[i];
            dec_cnt_nxt[i] = dec_cnt_r[i];
            cic_nxt[i] = cic_r[i];
            cic_vld_nxt[i] = 1'b0;
            iir_nxt[i] = iir_r[i];
            out_vld_nxt[i] = 1'b0;
            // two integrators, two combs at decimated rate
            if (vld[i]) begin
                int1_nxt[i] = int1_r[i] + 32'(stim[i]);
                int2_nxt[i] = int2_r[i] + int1_nxt[i];
                dec_cnt_nxt[i] = dec_cnt_r[i] + 3'h1;
                // decimation 1, 2, 4 or 8
                if (dec_cnt_r[i] >= 3'((4'h1 << ksel) - 4'h1)) begin
                    c1 = int2_nxt[i] - dly1_r[i];
                    c2 = c1 - dly2_r[i];
                    dly1_nxt[i] = int2_nxt[i];
                    dly2_nxt[i] = c1;
                    cic_nxt[i] = 16'(c2 >>> {ksel, 1'b0});
                    cic_vld_nxt[i] = 1'b1;
                    dec_cnt_nxt[i] = 3'h0;
                end
            end
            if (cic_vld_r[i]) begin
                iir_nxt[i] = 16'(y32 + ((32'(cic_r[i]) - y32) >>> (3'(isel) + 3'h1)));
                out_vld_nxt[i] = 1'b1;
            end
        end
    end

    // registers of every group
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            oe_r <= 1'b0;
            filt_r <= FILT_RST;
            for (int i = 0; i < 3; i++) begin
                ctrl_r[i] <= CTRL_RST;
                ac_cnt_r[i] <= '0;
                phase_r[i] <= 1'b0;
                int1_r[i] <= 32'h0;
                int2_r[i] <= 32'h0;
                dly1_r[i] <= 32'h0;
                dly2_r[i] <= 32'h0;
                dec_cnt_r[i] <= 3'h0;
                cic_r[i] <= 16'h0000;
                cic_vld_r[i] <= 1'b0;
                iir_r[i] <= 16'h0000;
                out_vld_r[i] <= 1'b0;
            end
        end else begin
            state_r <= state_nxt;
            scl_q_r <= scl;
            sda_q_r <= sda_in;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            nack_r <= nack_nxt;
            oe_r <= oe_nxt;
            filt_r <= filt_nxt;
            ctrl_r <= ctrl_nxt;
            ac_cnt_r <= ac_cnt_nxt;
            phase_r <= phase_nxt;
            int1_r <= int1_nxt;
            int2_r <= int2_nxt;
            dly1_r <= dly1_nxt;
            dly2_r <= dly2_nxt;
            dec_cnt_r <= dec_cnt_nxt;
            cic_r <= cic_nxt;
            cic_vld_r <= cic_vld_nxt;
            iir_r <= iir_nxt;
            out_vld_r <= out_vld_nxt;
        end
    end

    // checks on the design's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    decode_none_a: assert property (($countones(ctrl_r[0][2:0]) != 1) |-> exc[0] == 16'h0000)
        else $error("force applied with zero or several request bits");
    pos_level_a: assert property ((ctrl_r[2][2:0] == 3'h2) |-> exc[2] == EXC_VERT)
        else $error("positive excitation level wrong");
    neg_level_a: assert property ((ctrl_r[0][2:0] == 3'h1) |-> exc[0] == -EXC_HORZ)
        else $error("negative excitation level wrong");
    ac_toggle_a: assert property ((force_c[0] == FORCE_AC && ac_cnt_r[0] == CW'(HALF_CYC - 1))
        ##1 (force_c[0] == FORCE_AC) |-> phase_r[0] != $past(phase_r[0]))
        else $error("alternating force did not toggle at half period");
    sum_path_a: assert property (vld[0] |=> int1_r[0] == $past(int1_r[0])
        + 32'($past(samp[0]) + $past(exc[0])))
        else $error("excitation not added to sample");
    write_iso_a: assert property ((wr_en && ptr_r == X_CTRL_ADDR) |=> ctrl_r[0] == $past(shift_r)
        && $stable(ctrl_r[1]) && $stable(ctrl_r[2]))
        else $error("write to x control disturbed another axis");
    y_offset_a: assert property ((wr_en && ptr_r == Y_CTRL_ADDR) |=> ctrl_r[1] == $past(shift_r))
        else $error("y control not written at its offset");
    iir_step_a: assert property (cic_vld_r[0] |=> out_vld_r[0])
        else $error("recursive stage did not follow comb stage");
    dec_rate_a: assert property ((filt_r[1:0] == 2'h0 && vld[2]) |=> cic_vld_r[2])
        else $error("widest comb setting dropped a sample");
    axis_iso_a: assert property (!vld[1] |=> !cic_vld_r[1])
        else $error("axis path produced data without input");

    ac_seen_c: cover property (force_c[0] == FORCE_AC ##1 phase_r[0]);
    write_seen_c: cover property (wr_en && ptr_r == Z_CTRL_ADDR);
    read_seen_c: cover property (state_r == ST_RACK ##1 state_r == ST_RDATA);
    out_seen_c: cover property (out_vld_r[2] && force_c[2] == FORCE_POS);
endmodule // ast_self_test

// File: ast_host.sv
`timescale 1ns/1ps
// two-wire host model that runs the self test register accesses
module ast_host import ast_pkg::*; (
    input wire logic clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // clk cycles a bus step is held after its change; each step spans one cycle more
    localparam int Q = 4;
    // bus idle, both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one bus step, changed just after a clk edge and then held
    task automatic set(input logic c, input logic d);
        @(posedge clk);
        scl <= c;
        sda_low <= ~d;
        repeat (Q) @(posedge clk);
    endtask
    // lower the clock while data stays put
    task automatic fall();
        set(1'b0, ~sda_low);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        fall();
        set(1'b0, 1'b1);
        set(1'b1, 1'b1);
        set(1'b1, 1'b0);
    endtask
    // stop: data rises while clock high
    task automatic stop();
        fall();
        set(1'b0, 1'b0);
        set(1'b1, 1'b0);
        set(1'b1, 1'b1);
    endtask
    // one byte out, msb first, then sample the ack slot
    task automatic put(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            fall();
            set(1'b0, v[i]);
            set(1'b1, v[i]);
        end
        fall();
        set(1'b0, 1'b1);
        set(1'b1, 1'b1);
        ack = ~sda;
    endtask
    // one byte in, msb first, answered with a not-ack
    task automatic get(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            fall();
            set(1'b0, 1'b1);
            set(1'b1, 1'b1);
            v[i] = sda;
        end
        fall();
        set(1'b0, 1'b1);
        set(1'b1, 1'b1);
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        start();
        put({DEV_ADDR_DFLT, 1'b0}, k0);
        put(a, k1);
        put(d, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask
    // pointer write then repeated start and read
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic k0, k1, k2;
        start();
        put({DEV_ADDR_DFLT, 1'b0}, k0);
        put(a, k1);
        start();
        put({DEV_ADDR_DFLT, 1'b1}, k2);
        get(d);
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule // ast_host

// File: ast_self_test_tb.sv
`timescale 1ns/1ps
// compare and count
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module ast_self_test_tb import ast_pkg::*;;
    logic clk, rst, scl, sda_low, sda, sda_out, sda_oe, ok;
    logic signed [15:0] smp [3];
    wire logic signed [15:0] acc [3];
    wire [2:0] av;
    logic [2:0] sv;
    logic [7:0] rd;
    logic signed [15:0] mx, mn;
    int n_mismatch = 0;
    int total_checks = 0;
    int nval;
    int acc_sum; // sum of the tracked axis outputs in one feed
    int ax = 0; // axis whose outputs feed tracks
    // open-drain data wire with pull-up
    assign sda = ~(sda_low | (sda_oe & ~sda_out));
    ast_host host (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
    ast_self_test #(.HALF_CYC(8)) dut (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .sample_x(smp[0]), .sample_y(smp[1]),
        .sample_z(smp[2]), .sample_valid_x(sv[0]), .sample_valid_y(sv[1]),
        .sample_valid_z(sv[2]), .accel_x(acc[0]), .accel_y(acc[1]), .accel_z(acc[2]),
        .accel_valid_x(av[0]), .accel_valid_y(av[1]), .accel_valid_z(av[2]));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // result within one count of the expected level
    function automatic logic near(input logic signed [15:0] g, input int e);
        return (g - e <= 1) && (e - g <= 1);
    endfunction
    // a force delta within ten percent of the nominal level
    function automatic logic in_lim(input int d, input int l);
        return (d * 10 >= l * 9) && (d * 10 <= l * 11);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d, ok);
        `CHK(ok, 1'b1)
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.read_reg(a, rd, ok);
        `CHK({ok, rd}, {1'b1, e})
    endtask
    // n samples of value v on the axes in m, tracking outputs of axis ax
    task automatic feed(input logic [2:0] m, input logic signed [15:0] v, input int n);
        foreach (smp[i]) smp[i] <= v;
        mx = 16'sh8000;
        mn = 16'sh7FFF;
        nval = 0;
        acc_sum = 0;
        for (int i = 0; i < n + 4; i++) begin
            @(posedge clk);
            sv <= (i < n) ? m : 3'b000;
            if (av !== 3'b000) `CHK(av, m)
            if (av[ax] === 1'b1) begin
                nval++;
                acc_sum += acc[ax];
                if (acc[ax] > mx) mx = acc[ax];
                if (acc[ax] < mn) mn = acc[ax];
            end
        end
    endtask
    // software self test of one axis: baseline, positive, negative, alternating
    task automatic st_axis(input int a, input logic [7:0] adr, input int lvl);
        int base;
        int dp;
        int dn;
        ax = a;
        wr(adr, 8'h00);
        feed(3'b111, 16'sh0064, 16);
        feed(3'b111, 16'sh0064, 16);
        base = acc_sum / nval;
        wr(adr, 8'h02);
        feed(3'b111, 16'sh0064, 16);
        feed(3'b111, 16'sh0064, 16);
        dp = acc_sum / nval - base;
        wr(adr, 8'h01);
        feed(3'b111, 16'sh0064, 16);
        feed(3'b111, 16'sh0064, 16);
        dn = base - acc_sum / nval;
        `CHK(in_lim(dp, lvl) && in_lim(dn, lvl), 1'b1)
        wr(adr, 8'h04);
        feed(3'b111, 16'sh0064, 64);
        `CHK(in_lim(mx - base, lvl) && in_lim(base - mn, lvl), 1'b1)
        wr(adr, 8'h00);
        ax = 0;
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // hang guard
    initial begin
        #(60000 * 50);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        sv = 3'b000;
        foreach (smp[i]) smp[i] = 16'sh0000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rchk(X_CTRL_ADDR, 8'h00);
        rchk(Y_CTRL_ADDR, 8'h00);
        rchk(Z_CTRL_ADDR, 8'h00);
        rchk(8'h90, 8'h00);
        wr(X_CTRL_ADDR, 8'h00);
        wr(Y_CTRL_ADDR, 8'h00);
        wr(Z_CTRL_ADDR, 8'h00);
        // power-up self test of each axis in turn
        st_axis(0, X_CTRL_ADDR, EXC_HORZ);
        st_axis(1, Y_CTRL_ADDR, EXC_HORZ);
        st_axis(2, Z_CTRL_ADDR, EXC_VERT);
        // every request combination on x, zero external input
        for (int c = 0; c < 8; c++) begin
            wr(X_CTRL_ADDR, 8'(c));
            feed(3'b001, 16'sh0000, 24);
            if (c != 4) `CHK(near(acc[0], c == 1 ? -EXC_HORZ : c == 2 ? EXC_HORZ : 0), 1'b1)
        end
        // per-axis settings and additive excitation
        wr(X_CTRL_ADDR, 8'h02);
        wr(Z_CTRL_ADDR, 8'h01);
        rchk(X_CTRL_ADDR, 8'h02);
        rchk(Y_CTRL_ADDR, 8'h00);
        rchk(Z_CTRL_ADDR, 8'h01);
        wr(STAT_ADDR, 8'hFF);
        rchk(STAT_ADDR, 8'h28);
        feed(3'b111, 16'sh01F4, 24);
        `CHK(near(acc[0], 500 + EXC_HORZ), 1'b1)
        `CHK(near(acc[1], 500), 1'b1)
        `CHK(near(acc[2], 500 - EXC_VERT), 1'b1)
        wr(Z_CTRL_ADDR, 8'h02);
        feed(3'b100, 16'sh0000, 24);
        `CHK(near(acc[2], EXC_VERT), 1'b1)
        wr(X_CTRL_ADDR, 8'h00);
        feed(3'b001, 16'sh0000, 24);
        `CHK(near(acc[0], 0), 1'b1)
        // square wave swings between both levels
        wr(X_CTRL_ADDR, 8'h04);
        feed(3'b001, 16'sh0000, 64);
        `CHK(mx > 1750 && mx <= EXC_HORZ, 1'b1)
        `CHK(mn < -1750 && mn >= -EXC_HORZ, 1'b1)
        // filter settings: one output per 2^k samples
        wr(X_CTRL_ADDR, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(FILT_ADDR, 8'(5 * k));
            rchk(FILT_ADDR, 8'(5 * k));
            feed(3'b001, 16'sh0000, 16);
            `CHK(nval, 16 >> k)
        end
        report_and_stop();
    end
endmodule // ast_self_test_tb
